// ==== rtl/pllcd_defines.vh ====
// Purpose: register indices, reset values, masks and field positions of the clock tree config
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef PLLCD_DEFINES_VH
`define PLLCD_DEFINES_VH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define PLLCD_IDX_PLL_TOP   7'h36
`define PLLCD_IDX_PLL_LOW   7'h38
`define PLLCD_IDX_N_PDM     7'h39
`define PLLCD_IDX_M_ADC     7'h3a
`define PLLCD_IDX_DAC_TOP   7'h3b
`define PLLCD_IDX_PB_LOW    7'h3c
`define PLLCD_IDX_SB_LOW    7'h3d
`define PLLCD_IDX_DIV_EN    7'h44
`define PLLCD_IDX_DIV_EN2   7'h45
`define PLLCD_IDX_STATUS    7'h7e
`define PLLCD_IDX_CTRL      7'h7f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PLLCD_RST_PLL_TOP   8'h00
`define PLLCD_RST_PLL_LOW   8'h08
`define PLLCD_RST_N_PDM     8'h20
`define PLLCD_RST_M_ADC     8'h04
`define PLLCD_RST_DAC_TOP   8'h00
`define PLLCD_RST_PB_LOW    8'h01
`define PLLCD_RST_SB_LOW    8'h01
`define PLLCD_RST_DIV_EN    8'h00
`define PLLCD_RST_DIV_EN2   8'h00
`define PLLCD_RST_CTRL      8'h00

// ----------------------------------------------------------------
// writable bit masks, reserved bits read zero except in pll_top_r and div_en2_r, which are written unmasked
// ----------------------------------------------------------------
`define PLLCD_MSK_FULL      8'hff
`define PLLCD_MSK_N_PDM     8'hfc
`define PLLCD_MSK_DAC_TOP   8'h36
`define PLLCD_MSK_DIV_EN    8'h07
`define PLLCD_MSK_CTRL      8'h01

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PLLCD_N_LSB         5
`define PLLCD_PDM_LSB       2
`define PLLCD_M_LSB         2
`define PLLCD_ADC_LSB       0
`define PLLCD_DAC_LSB       4
`define PLLCD_PB_TOP_BIT    2
`define PLLCD_SB_TOP_BIT    1
`define PLLCD_PLL_TOP_BIT   7
`define PLLCD_N_EN_BIT      2
`define PLLCD_M_EN_BIT      1
`define PLLCD_PDM_EN_BIT    0
`define PLLCD_ADC_EN_BIT    6
`define PLLCD_DAC_EN_BIT    4
`define PLLCD_PB_EN_BIT     3
`define PLLCD_SB_EN_BIT     2
`define PLLCD_AUTO_BIT      0

// ----------------------------------------------------------------
// codes used while automatic detection owns the clock tree
// ----------------------------------------------------------------
`define PLLCD_AUTO_N        3'h1
`define PLLCD_AUTO_PDM      3'h0
`define PLLCD_AUTO_M        6'h01
`define PLLCD_AUTO_MOD      2'h0
`define PLLCD_AUTO_BCLK     9'h001
`define PLLCD_AUTO_PLL      9'h008

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define PLLCD_RESP_OKAY     2'h0
`define PLLCD_RESP_SLVERR   2'h2

`endif

// ==== rtl/pllcd_divider.v ====
// Purpose: divide aclk by a programmed ratio into a one-cycle tick train
// Assumes: ratio is never zero
// Notes:   the ratio is sampled only at period end, so a change never makes a short period
`timescale 1ns/10ps
module pllcd_divider
#(
   parameter RW = 4
)
(
   input  wire          aclk,
   input  wire          aresetn,
   input  wire          run,
   input  wire [RW-1:0] ratio,
   output wire          tick
);
   localparam [RW-1:0] ONE = {{(RW-1){1'b0}}, 1'b1};

   reg [RW-1:0] cnt_r;
   reg          tick_r;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_r  <= {RW{1'b0}};
         tick_r <= 1'b0;
      end
      else if (!run)
      begin
         cnt_r  <= {RW{1'b0}};
         tick_r <= 1'b0;
      end
      else if (cnt_r == {RW{1'b0}})
      begin
         cnt_r  <= ratio - ONE;
         tick_r <= 1'b1;
      end
      else
      begin
         cnt_r  <= cnt_r - ONE;
         tick_r <= 1'b0;
      end
   end

   assign tick = tick_r;
endmodule // pllcd_divider

// ==== rtl/pllcd_ratio.v ====
// Purpose: turn a divider code into a division ratio
// Assumes: POW2=0 means code 0 selects 2**CW; POW2=1 means ratio 2**code up to MAXC
// Notes:   reserved power-of-two codes clamp to the largest valid ratio
`timescale 1ns/10ps
module pllcd_ratio
#(
   parameter CW   = 3,
   parameter RW   = 4,
   parameter POW2 = 0,
   parameter MAXC = 4
)
(
   input  wire [CW-1:0] code,
   output reg  [RW-1:0] ratio
);
   localparam [CW-1:0] MAXV = MAXC;
   localparam [RW-1:0] ONE  = {{(RW-1){1'b0}}, 1'b1};

   always @*
   begin
      if (POW2 != 0)
      begin
         // clamp keeps the clock alive on a reserved code
         ratio = ONE << ((code > MAXV) ? MAXV : code);
      end
      else if (code == {CW{1'b0}})
      begin
         ratio = ONE << CW;
      end
      else
      begin
         ratio = {{(RW-CW){1'b0}}, code};
      end
   end
endmodule // pllcd_ratio

// ==== rtl/pllcd_top.v ====
// Purpose: clock tree divider and pll multiplier configuration with an axi4-lite slave
// Assumes: aclk is the divider input clock; synchronous active-low reset
// Notes:   divider outputs are one-cycle ticks at aclk/ratio
`timescale 1ns/10ps
`include "pllcd_defines.vh"
module pllcd_top
#(
   parameter AW = 12
)
(
   input  wire          aclk,
   input  wire          aresetn,
   input  wire [AW-1:0] s_axi_awaddr,
   input  wire [2:0]    s_axi_awprot,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   output wire [1:0]    s_axi_bresp,
   output wire          s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [AW-1:0] s_axi_araddr,
   input  wire [2:0]    s_axi_arprot,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   output wire [31:0]   s_axi_rdata,
   output wire [1:0]    s_axi_rresp,
   output wire          s_axi_rvalid,
   input  wire          s_axi_rready,
   output wire [8:0]    pll_int_mult,
   output wire          n_stage_tick,
   output wire          m_stage_tick,
   output wire          density_mod_tick,
   output wire          adc_mod_tick,
   output wire          dac_mod_tick,
   output wire          primary_bitclk_tick,
   output wire          secondary_bitclk_tick
);
   // ----------------------------------------------------------------
   // registers and bus state
   // ----------------------------------------------------------------
   reg  [7:0]    pll_top_r;
   reg  [7:0]    pll_low_r;
   reg  [7:0]    n_pdm_r;
   reg  [7:0]    m_adc_r;
   reg  [7:0]    dac_top_r;
   reg  [7:0]    pb_low_r;
   reg  [7:0]    sb_low_r;
   reg  [7:0]    div_en_r;
   reg  [7:0]    div_en2_r;
   reg  [7:0]    ctrl_r;
   reg  [8:0]    pll_mult_r;
   reg           awready_r;
   reg           awv_r;
   reg  [AW-1:0] awaddr_r;
   reg           wready_r;
   reg           wv_r;
   reg  [7:0]    wdat_r;
   reg           wstb_r;
   reg           bvalid_r;
   reg  [1:0]    bresp_r;
   reg           arready_r;
   reg           rvalid_r;
   reg  [31:0]   rdata_r;
   reg  [1:0]    rresp_r;
   reg  [7:0]    rd_dat;
   reg           rd_ok;
   wire          wr_fire;
   wire          wr_ok;
   wire [6:0]    wr_idx;
   wire          auto_on;
   wire [2:0]    n_code;
   wire [2:0]    pdm_code;
   wire [5:0]    m_code;
   wire [1:0]    adc_code;
   wire [1:0]    dac_code;
   wire [8:0]    pb_code;
   wire [8:0]    sb_code;
   wire [8:0]    pll_code;
   wire [6:0]    run;
   wire [3:0]    n_ratio;
   wire [4:0]    pdm_ratio;
   wire [6:0]    m_ratio;
   wire [2:0]    adc_ratio;
   wire [2:0]    dac_ratio;
   wire [9:0]    pb_ratio;
   wire [9:0]    sb_ratio;

   function mapped;
      input [AW-1:0] addr;
      begin
         mapped = (addr[AW-1:9] == {(AW-9){1'b0}}) &&
                  ((addr[8:2] == `PLLCD_IDX_PLL_TOP) || (addr[8:2] == `PLLCD_IDX_PLL_LOW) ||
                   (addr[8:2] == `PLLCD_IDX_N_PDM)   || (addr[8:2] == `PLLCD_IDX_M_ADC)   ||
                   (addr[8:2] == `PLLCD_IDX_DAC_TOP) || (addr[8:2] == `PLLCD_IDX_PB_LOW)  ||
                   (addr[8:2] == `PLLCD_IDX_SB_LOW)  || (addr[8:2] == `PLLCD_IDX_DIV_EN)  ||
                   (addr[8:2] == `PLLCD_IDX_DIV_EN2) || (addr[8:2] == `PLLCD_IDX_STATUS)  ||
                   (addr[8:2] == `PLLCD_IDX_CTRL));
      end
   endfunction

   // ----------------------------------------------------------------
   // write channel: address and data taken in either order
   // ----------------------------------------------------------------
   assign wr_fire = awv_r & wv_r & ~bvalid_r;
   assign wr_ok   = mapped(awaddr_r);
   assign wr_idx  = awaddr_r[8:2];

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_r <= 1'b0;
         awv_r     <= 1'b0;
         awaddr_r  <= {AW{1'b0}};
         wready_r  <= 1'b0;
         wv_r      <= 1'b0;
         wdat_r    <= 8'h00;
         wstb_r    <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `PLLCD_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && awready_r)
         begin
            awv_r     <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
            awready_r <= 1'b0;
         end
         else if (bvalid_r && s_axi_bready)
         begin
            awv_r     <= 1'b0;
            awready_r <= 1'b1;
         end
         else if (!awv_r)
         begin
            awready_r <= 1'b1;
         end
         if (s_axi_wvalid && wready_r)
         begin
            wv_r     <= 1'b1;
            wdat_r   <= s_axi_wdata[7:0];
            wstb_r   <= s_axi_wstrb[0];
            wready_r <= 1'b0;
         end
         else if (bvalid_r && s_axi_bready)
         begin
            wv_r     <= 1'b0;
            wready_r <= 1'b1;
         end
         else if (!wv_r)
         begin
            wready_r <= 1'b1;
         end
         if (wr_fire)
         begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_ok ? `PLLCD_RESP_OKAY : `PLLCD_RESP_SLVERR;
         end
         else if (bvalid_r && s_axi_bready)
         begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   // a cleared lane-0 strobe leaves the register untouched, the write still answers
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pll_top_r <= `PLLCD_RST_PLL_TOP;
         pll_low_r <= `PLLCD_RST_PLL_LOW;
         n_pdm_r   <= `PLLCD_RST_N_PDM;
         m_adc_r   <= `PLLCD_RST_M_ADC;
         dac_top_r <= `PLLCD_RST_DAC_TOP;
         pb_low_r  <= `PLLCD_RST_PB_LOW;
         sb_low_r  <= `PLLCD_RST_SB_LOW;
         div_en_r  <= `PLLCD_RST_DIV_EN;
         div_en2_r <= `PLLCD_RST_DIV_EN2;
         ctrl_r    <= `PLLCD_RST_CTRL;
      end
      else if (wr_fire && wstb_r)
      begin
         case (wr_idx)
            `PLLCD_IDX_PLL_TOP: pll_top_r <= wdat_r;
            `PLLCD_IDX_PLL_LOW: pll_low_r <= wdat_r;
            `PLLCD_IDX_N_PDM:   n_pdm_r   <= wdat_r & `PLLCD_MSK_N_PDM;
            `PLLCD_IDX_M_ADC:   m_adc_r   <= wdat_r;
            `PLLCD_IDX_DAC_TOP: dac_top_r <= wdat_r & `PLLCD_MSK_DAC_TOP;
            `PLLCD_IDX_PB_LOW:  pb_low_r  <= wdat_r;
            `PLLCD_IDX_SB_LOW:  sb_low_r  <= wdat_r;
            `PLLCD_IDX_DIV_EN:  div_en_r  <= wdat_r & `PLLCD_MSK_DIV_EN;
            `PLLCD_IDX_DIV_EN2: div_en2_r <= wdat_r;
            `PLLCD_IDX_CTRL:    ctrl_r    <= wdat_r & `PLLCD_MSK_CTRL;
            default:            ctrl_r    <= ctrl_r;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read channel: one cycle from address to data
   // ----------------------------------------------------------------
   always @*
   begin
      rd_ok = mapped(s_axi_araddr);
      case (s_axi_araddr[8:2])
         `PLLCD_IDX_PLL_TOP: rd_dat = pll_top_r;
         `PLLCD_IDX_PLL_LOW: rd_dat = pll_low_r;
         `PLLCD_IDX_N_PDM:   rd_dat = n_pdm_r;
         `PLLCD_IDX_M_ADC:   rd_dat = m_adc_r;
         `PLLCD_IDX_DAC_TOP: rd_dat = dac_top_r;
         `PLLCD_IDX_PB_LOW:  rd_dat = pb_low_r;
         `PLLCD_IDX_SB_LOW:  rd_dat = sb_low_r;
         `PLLCD_IDX_DIV_EN:  rd_dat = div_en_r;
         `PLLCD_IDX_DIV_EN2: rd_dat = div_en2_r;
         `PLLCD_IDX_STATUS:  rd_dat = {auto_on, run};
         `PLLCD_IDX_CTRL:    rd_dat = ctrl_r;
         default:            rd_dat = 8'h00;
      endcase
      if (!rd_ok)
      begin
         rd_dat = 8'h00;
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= `PLLCD_RESP_OKAY;
      end
      else if (s_axi_arvalid && arready_r)
      begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= {24'h00_0000, rd_dat};
         rresp_r   <= rd_ok ? `PLLCD_RESP_OKAY : `PLLCD_RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready)
      begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b1;
      end
      else if (!rvalid_r)
      begin
         arready_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // effective codes
   // ----------------------------------------------------------------
   // detection owns the ratios; enables stay with software
   assign auto_on  = ctrl_r[`PLLCD_AUTO_BIT];
   assign n_code   = auto_on ? `PLLCD_AUTO_N : n_pdm_r[`PLLCD_N_LSB +: 3];
   assign pdm_code = auto_on ? `PLLCD_AUTO_PDM : n_pdm_r[`PLLCD_PDM_LSB +: 3];
   assign m_code   = auto_on ? `PLLCD_AUTO_M : m_adc_r[`PLLCD_M_LSB +: 6];
   assign adc_code = auto_on ? `PLLCD_AUTO_MOD : m_adc_r[`PLLCD_ADC_LSB +: 2];
   assign dac_code = auto_on ? `PLLCD_AUTO_MOD : dac_top_r[`PLLCD_DAC_LSB +: 2];
   assign pb_code  = auto_on ? `PLLCD_AUTO_BCLK :
                     {dac_top_r[`PLLCD_PB_TOP_BIT], pb_low_r};
   assign sb_code  = auto_on ? `PLLCD_AUTO_BCLK :
                     {dac_top_r[`PLLCD_SB_TOP_BIT], sb_low_r};
   assign pll_code = auto_on ? `PLLCD_AUTO_PLL :
                     {pll_top_r[`PLLCD_PLL_TOP_BIT], pll_low_r};

   assign run = {div_en2_r[`PLLCD_PB_EN_BIT], div_en2_r[`PLLCD_SB_EN_BIT],
                 div_en2_r[`PLLCD_DAC_EN_BIT], div_en2_r[`PLLCD_ADC_EN_BIT],
                 div_en_r[`PLLCD_PDM_EN_BIT], div_en_r[`PLLCD_M_EN_BIT],
                 div_en_r[`PLLCD_N_EN_BIT]};

   // reserved code 0 runs the pll at ratio 1 rather than stalling it
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pll_mult_r <= `PLLCD_AUTO_PLL;
      end
      else
      begin
         pll_mult_r <= (pll_code == 9'h000) ? 9'h001 : pll_code;
      end
   end

   // ----------------------------------------------------------------
   // code decoders
   // ----------------------------------------------------------------
   pllcd_ratio #(.CW(3), .RW(4), .POW2(0), .MAXC(0)) u_n_ratio
      (.code(n_code), .ratio(n_ratio));
   pllcd_ratio #(.CW(3), .RW(5), .POW2(1), .MAXC(4)) u_pdm_ratio
      (.code(pdm_code), .ratio(pdm_ratio));
   pllcd_ratio #(.CW(6), .RW(7), .POW2(0), .MAXC(0)) u_m_ratio
      (.code(m_code), .ratio(m_ratio));
   pllcd_ratio #(.CW(2), .RW(3), .POW2(1), .MAXC(2)) u_adc_ratio
      (.code(adc_code), .ratio(adc_ratio));
   pllcd_ratio #(.CW(2), .RW(3), .POW2(1), .MAXC(2)) u_dac_ratio
      (.code(dac_code), .ratio(dac_ratio));
   pllcd_ratio #(.CW(9), .RW(10), .POW2(0), .MAXC(0)) u_pb_ratio
      (.code(pb_code), .ratio(pb_ratio));
   pllcd_ratio #(.CW(9), .RW(10), .POW2(0), .MAXC(0)) u_sb_ratio
      (.code(sb_code), .ratio(sb_ratio));

   // ----------------------------------------------------------------
   // dividers
   // ----------------------------------------------------------------
   pllcd_divider #(.RW(4)) u_n_div
      (.aclk(aclk), .aresetn(aresetn), .run(run[0]), .ratio(n_ratio), .tick(n_stage_tick));
   pllcd_divider #(.RW(7)) u_m_div
      (.aclk(aclk), .aresetn(aresetn), .run(run[1]), .ratio(m_ratio), .tick(m_stage_tick));
   pllcd_divider #(.RW(5)) u_density_mod_divider_code
      (.aclk(aclk), .aresetn(aresetn), .run(run[2]), .ratio(pdm_ratio),
       .tick(density_mod_tick));
   pllcd_divider #(.RW(3)) u_adc_div
      (.aclk(aclk), .aresetn(aresetn), .run(run[3]), .ratio(adc_ratio), .tick(adc_mod_tick));
   pllcd_divider #(.RW(3)) u_dac_div
      (.aclk(aclk), .aresetn(aresetn), .run(run[4]), .ratio(dac_ratio), .tick(dac_mod_tick));
   pllcd_divider #(.RW(10)) u_sb_div
      (.aclk(aclk), .aresetn(aresetn), .run(run[5]), .ratio(sb_ratio),
       .tick(secondary_bitclk_tick));
   pllcd_divider #(.RW(10)) u_pb_div
      (.aclk(aclk), .aresetn(aresetn), .run(run[6]), .ratio(pb_ratio),
       .tick(primary_bitclk_tick));

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign pll_int_mult  = pll_mult_r;
endmodule // pllcd_top

// ==== testbench/pllcd_top_properties.sv ====
// Purpose: bus and output checks for pllcd_top
// Assumes: one clock, synchronous active-low reset
// Notes:   sees top ports only
`timescale 1ns/10ps
module pllcd_props
(
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [8:0]  pll_int_mult
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence aw_w_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence b_done;
      s_axi_bvalid && s_axi_bready;
   endsequence
   chk_b_after_both: assert property (aw_w_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer late or early");
   chk_b_reopens: assert property (b_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write slots not reopened");
   chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
                                 s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
                                  s_axi_rvalid && !s_axi_arready)
      else $error("read answer not next cycle");
   chk_r_reopens: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read slot not reopened");
   chk_rdata_top_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   chk_mult_nonzero: assert property (pll_int_mult != 9'h000)
      else $error("multiplier shows zero");
   chk_mult_reset: assert property ($rose(aresetn) |-> pll_int_mult == 9'h008)
      else $error("multiplier reset value wrong");
endmodule // pllcd_props
bind pllcd_top pllcd_props u_pllcd_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .pll_int_mult(pll_int_mult));

// ==== testbench/pllcd_top_tb.sv ====
// Purpose: self-checking bench for pllcd_top
// Assumes: axi4-lite master, one transfer at a time
// Notes:   ratios measured as tick spacing
`timescale 1ns/10ps
`define CHK(a,e) begin checked=checked+1; if ((a)!==(e)) begin n_mismatch=n_mismatch+1; \
   $display("ERROR %0t got %0h exp %0h",$time,a,e); end end
module pllcd_top_tb;
   reg         aclk = 0, aresetn = 0;
   reg  [11:0] aw = 0, ar = 0;
   reg  [31:0] wd = 0;
   reg         awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   wire        awr, wr_y, bv, arr, rv;
   wire [1:0]  br, rr;
   wire [31:0] rd_d;
   wire [8:0]  mult;
   wire [6:0]  tk;
   integer     n_mismatch = 0, checked = 0;
   always #5 aclk = ~aclk;
   pllcd_top u_pllcd_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wr_y), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .pll_int_mult(mult), .n_stage_tick(tk[0]),
      .m_stage_tick(tk[1]), .density_mod_tick(tk[2]), .adc_mod_tick(tk[3]),
      .dac_mod_tick(tk[4]), .primary_bitclk_tick(tk[5]), .secondary_bitclk_tick(tk[6]));
   // ------
   // bus tasks
   // ------
   task wr(input [9:0] i, input [7:0] d, input [1:0] e);
      reg dn;
      begin
         dn = 0;
         @(posedge aclk);
         aw <= {i, 2'h0};
         wd <= {24'h0, d};
         awv <= 1'b1;
         wv <= 1'b1;
         bry <= 1'b1;
         while (!dn)
         begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_y) wv <= 1'b0;
            if (bv && bry)
            begin
               dn = 1;
               bry <= 1'b0;
               `CHK(br, e)
            end
         end
      end
   endtask
   task rd(input [9:0] i, input [7:0] d, input [1:0] e);
      reg dn;
      begin
         dn = 0;
         @(posedge aclk);
         ar <= {i, 2'h0};
         arv <= 1'b1;
         rry <= 1'b1;
         while (!dn)
         begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'b0;
            if (rv && rry)
            begin
               dn = 1;
               rry <= 1'b0;
               `CHK(rd_d, d)
               `CHK(rr, e)
            end
         end
      end
   endtask
   // second full spacing (third wait) is taken so a code change mid-period cannot skew it
   task meas(input integer s, input integer e);
      integer j, k;
      begin
         for (j = 0; j < 3; j = j + 1)
         begin
            k = 0;
            @(posedge aclk);
            while (tk[s] !== 1'b1)
            begin
               k = k + 1;
               @(posedge aclk);
            end
         end
         `CHK(k + 1, e)
      end
   endtask
   // ------
   // scenarios
   // ------
   task t_reset;
      begin
         @(posedge aclk);
         `CHK(mult, 9'h008)
         `CHK(tk, 7'h00)
         rd(10'h38, 8'h08, 2'h0);
         rd(10'h39, 8'h20, 2'h0);
         rd(10'h3a, 8'h04, 2'h0);
         rd(10'h3b, 8'h00, 2'h0);
         rd(10'h3c, 8'h01, 2'h0);
      end
   endtask
   task t_mask;
      begin
         wr(10'h39, 8'hfc, 2'h0);
         rd(10'h39, 8'hfc, 2'h0);
         wr(10'h3b, 8'h36, 2'h0);
         rd(10'h3b, 8'h36, 2'h0);
      end
   endtask
   task t_mult;
      begin
         wr(10'h36, 8'h80, 2'h0);
         wr(10'h38, 8'h00, 2'h0);
         @(posedge aclk);
         `CHK(mult, 9'h100)
         wr(10'h38, 8'hff, 2'h0);
         @(posedge aclk);
         `CHK(mult, 9'h1ff)
         wr(10'h36, 8'h00, 2'h0);
         wr(10'h38, 8'h00, 2'h0);
         @(posedge aclk);
         `CHK(mult, 9'h001)
      end
   endtask
   task t_div;
      begin
         wr(10'h39, 8'h70, 2'h0);
         wr(10'h3a, 8'h16, 2'h0);
         wr(10'h3b, 8'h14, 2'h0);
         wr(10'h3c, 8'h03, 2'h0);
         wr(10'h3d, 8'h00, 2'h0);
         wr(10'h44, 8'h07, 2'h0);
         wr(10'h45, 8'h5c, 2'h0);
         meas(0, 3);
         meas(2, 16);
         meas(1, 5);
         meas(3, 4);
         meas(4, 2);
         meas(5, 259);
         meas(6, 512);
         wr(10'h39, 8'h18, 2'h0);
         wr(10'h3a, 8'h03, 2'h0);
         wr(10'h3b, 8'h02, 2'h0);
         wr(10'h3d, 8'h05, 2'h0);
         meas(0, 8);
         meas(2, 16);
         meas(1, 64);
         meas(3, 4);
         meas(4, 1);
         meas(6, 261);
      end
   endtask
   task t_auto;
      begin
         wr(10'h7f, 8'h01, 2'h0);
         @(posedge aclk);
         `CHK(mult, 9'h008)
         rd(10'h7e, 8'hff, 2'h0);
         meas(0, 1);
         meas(1, 1);
         wr(10'h7f, 8'h00, 2'h0);
         meas(0, 8);
         wr(10'h44, 8'h00, 2'h0);
         repeat (2) @(posedge aclk);
         repeat (20)
         begin
            @(posedge aclk);
            `CHK(tk[2:0], 3'h0)
         end
      end
   endtask
   task t_unmapped;
      begin
         wr(10'h50, 8'h55, 2'h2);
         rd(10'h50, 8'h00, 2'h2);
         rd(10'h238, 8'h00, 2'h2);
      end
   endtask
   // reset in mid-run must bring back the reset codes and stop the ticks
   task t_rerst;
      begin
         aresetn <= 1'b0;
         repeat (2) @(posedge aclk);
         aresetn <= 1'b1;
         @(posedge aclk);
         `CHK(mult, 9'h008)
         `CHK(tk, 7'h00)
         rd(10'h38, 8'h08, 2'h0);
         rd(10'h45, 8'h00, 2'h0);
      end
   endtask
   task end_sim;
      begin
         $display("mismatches %0d checks %0d", n_mismatch, checked);
         if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_mask;
      t_mult;
      t_div;
      t_auto;
      t_unmapped;
      t_rerst;
      end_sim;
   end
   initial
   begin
      #300000;
      n_mismatch = n_mismatch + 1;
      end_sim;
   end
endmodule // pllcd_top_tb
